// ==== common/scpl_cfg.svh ====
// Register offsets, field positions, reset values and memory window bounds.
`ifndef SCPL_CFG_SVH
`define SCPL_CFG_SVH
// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SCPL_ADDR_CFG0 16'h1010
`define SCPL_ADDR_CFG1 16'h1011
`define SCPL_ADDR_CFG2 16'h1012
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCPL_C0_COLD 7
`define SCPL_C0_LOWDRV 6
`define SCPL_C0_PFWAIT 5
`define SCPL_C0_CFAULT 4
`define SCPL_C0_HV 3
`define SCPL_C0_PIN 2
`define SCPL_C0_MODE 0
`define SCPL_C1_AWDIS 4
`define SCPL_C1_MEMOFF 2
`define SCPL_C2_LOCK 0
// ----------------------------------------------------------------------------
// Write masks and reset values
// ----------------------------------------------------------------------------
`define SCPL_C0_WMASK 8'h60
`define SCPL_C1_WMASK 8'h14
`define SCPL_C1_PROT 8'h14
`define SCPL_C2_PROT 8'he7
`define SCPL_C0_RST 8'h00
`define SCPL_C1_RST 8'h00
`define SCPL_C2_RST 8'h00
// ----------------------------------------------------------------------------
// Memory windows
// ----------------------------------------------------------------------------
`define SCPL_INT_LO 16'h7000
`define SCPL_INT_HI 16'h7fff
`define SCPL_GONE_LO 16'h4000
`define SCPL_LOWX_LO 16'h2000
`define SCPL_LOWX_HI 16'h3fff
`define SCPL_UPX_LO 16'h8000
`define SCPL_PFX_LO 16'h10c0
`define SCPL_PFX_HI 16'h10ff
`define SCPL_PF1_LO 16'h1020
`define SCPL_PF1_HI 16'h102f
`endif

// ==== common/scpl_pkg.sv ====
// Types shared by the system configuration block.
package scpl_pkg;
  typedef enum logic [1:0] {
    SCPL_MODE_SINGLE,
    SCPL_MODE_EXPANDED,
    SCPL_MODE_PROC
  } scpl_mode_t;
  typedef enum logic [1:0] {
    SCPL_PORT_GPIO,
    SCPL_PORT_SELECTS,
    SCPL_PORT_BUSCTL
  } scpl_port_fn_t;
endpackage : scpl_pkg

// ==== rtl/scpl_decode.sv ====
// Address decoder that routes a processor access to internal or external memory.
`timescale 1ns/1ns
`include "scpl_cfg.svh"
module scpl_decode (
  input wire logic [15:0] i_addr,
  input wire logic i_proc_mode,
  input wire logic i_mem_off,
  output logic o_internal,
  output logic o_external,
  output logic o_low_window,
  output logic o_upper_window,
  output logic o_periph_window
);
  logic in_int;
  logic in_gone;
  logic in_pf1;
  // ----------------------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------------------
  // Classify the address against the fixed windows.
  always_comb begin
    in_int = (i_addr >= `SCPL_INT_LO) && (i_addr <= `SCPL_INT_HI);
    in_gone = (i_addr >= `SCPL_GONE_LO) && (i_addr <= `SCPL_INT_HI);
    in_pf1 = (i_addr >= `SCPL_PF1_LO) && (i_addr <= `SCPL_PF1_HI);
    o_low_window = (i_addr >= `SCPL_LOWX_LO) && (i_addr <= `SCPL_LOWX_HI);
    o_upper_window = (i_addr >= `SCPL_UPX_LO);
    o_periph_window = (i_addr >= `SCPL_PFX_LO) && (i_addr <= `SCPL_PFX_HI);
    // Internal program memory answers unless it is switched off in processor mode.
    o_internal = in_int && !(i_proc_mode && i_mem_off);
    // Once memory is back on, the whole 4000h-7FFFh span is not routed out.
    o_external = i_proc_mode
      ? (o_low_window || o_upper_window || o_periph_window || in_pf1
         || (in_gone && i_mem_off))
      : (o_low_window || o_upper_window || o_periph_window);
  end
endmodule : scpl_decode

// ==== rtl/scpl_top.sv ====
// System configuration registers, memory mode capture and privilege lock.
`timescale 1ns/1ns
`include "scpl_cfg.svh"
module scpl_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_mode_select_pin,
  input wire logic i_mode_pin_high_voltage,
  input wire logic i_clock_fault_seen,
  input wire logic [15:0] i_addr,
  input wire logic i_access,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  input wire logic i_pf_access,
  input wire logic [7:0] i_pf_num,
  input wire logic i_opcode_fetch,
  input wire logic i_wait_n,
  input wire scpl_pkg::scpl_port_fn_t i_port_fn_req,
  input wire logic [5:0] i_select_enable,
  input wire logic [3:0] i_periph_prot_wdata,
  input wire logic i_periph_prot_we,
  output logic [7:0] o_rdata,
  output scpl_pkg::scpl_mode_t o_mode,
  output scpl_pkg::scpl_port_fn_t o_port_fn,
  output logic o_privileged,
  output logic o_internal_sel,
  output logic o_external_strobe_n,
  output logic o_opcode_fetch_out_n,
  output logic o_wait_stall,
  output logic o_low_window_select_a_n,
  output logic o_low_window_select_b_n,
  output logic o_upper_bank_select_1_n,
  output logic o_upper_bank_select_2_n,
  output logic o_upper_bank_select_3_n,
  output logic o_periph_ext_select_n,
  output logic [7:0] o_cfg0,
  output logic [7:0] o_cfg1,
  output logic [7:0] o_cfg2,
  output logic [3:0] o_periph_prot
);
  import scpl_pkg::*;

  // ----------------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------------
  // Map a short peripheral number or full address onto a register index.
  function automatic logic [1:0] reg_index(input logic [15:0] a);
    reg_index = 2'd3;
    if (a == `SCPL_ADDR_CFG0) begin
      reg_index = 2'd0;
    end else if (a == `SCPL_ADDR_CFG1) begin
      reg_index = 2'd1;
    end else if (a == `SCPL_ADDR_CFG2) begin
      reg_index = 2'd2;
    end
  endfunction : reg_index

  logic [15:0] eff_addr;
  logic [1:0] widx;
  logic any_access;
  logic [7:0] cfg0;
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [3:0] pprot;
  logic boot_pending;
  logic proc_mode;
  logic started;
  logic [7:0] next_cfg0;
  logic [7:0] next_cfg1;
  logic [7:0] next_cfg2;
  logic [3:0] next_pprot;
  logic next_boot_pending;
  logic next_proc_mode;
  logic next_started;
  logic locked;
  logic dec_internal;
  logic dec_external;
  logic dec_low;
  logic dec_upper;
  logic dec_periph;

  // Peripheral numbers sit in frame page 10xxh, so the low byte picks the register.
  always_comb begin
    eff_addr = i_pf_access ? {8'h10, i_pf_num} : i_addr;
    any_access = i_access || i_pf_access;
    widx = reg_index(eff_addr);
    locked = cfg2[`SCPL_C2_LOCK];
  end

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  // Next values for the three registers, mode capture and external protect bits.
  always_comb begin
    next_cfg0 = cfg0;
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_pprot = pprot;
    next_proc_mode = proc_mode;
    next_boot_pending = 1'b0;
    // Only a real release marks the start; edges held in reset must not count.
    next_started = started || (boot_pending && !i_rst);
    // The first cycle after release catches the mode pin.
    if (boot_pending) begin
      next_proc_mode = i_mode_select_pin;
      next_cfg1[`SCPL_C1_MEMOFF] = i_mode_select_pin;
    end
    // Pin and mode status fields track their sources, clock fault latches until written 0; power_on_origin_flag is set on the first release only.
    next_cfg0[`SCPL_C0_CFAULT] = cfg0[`SCPL_C0_CFAULT] | i_clock_fault_seen;
    next_cfg0[`SCPL_C0_HV] = i_mode_pin_high_voltage;
    next_cfg0[`SCPL_C0_PIN] = i_mode_select_pin;
    next_cfg0[`SCPL_C0_MODE] = boot_pending ? i_mode_select_pin : proc_mode;
    if (boot_pending && !started) begin
      next_cfg0[`SCPL_C0_COLD] = 1'b1;
    end
    // Protected bits keep their value while locked; the override pin plays no part.
    if (any_access && i_write && !boot_pending) begin
      case (widx)
        2'd0: begin
          next_cfg0 = (next_cfg0 & ~`SCPL_C0_WMASK) | (i_wdata & `SCPL_C0_WMASK);
          if (!i_wdata[`SCPL_C0_COLD]) begin
            next_cfg0[`SCPL_C0_COLD] = 1'b0;
          end
          if (!i_wdata[`SCPL_C0_CFAULT] && !i_clock_fault_seen) begin
            next_cfg0[`SCPL_C0_CFAULT] = 1'b0;
          end
        end
        2'd1: begin
          if (!locked) begin
            next_cfg1 = i_wdata & `SCPL_C1_WMASK;
          end
        end
        2'd2: begin
          if (locked) begin
            // Only self-test bits may change; lock stays set until reset.
            next_cfg2 = (cfg2 & `SCPL_C2_PROT) | (i_wdata & ~`SCPL_C2_PROT);
          end else begin
            next_cfg2 = i_wdata;
          end
        end
        default: begin
          next_cfg2 = next_cfg2;
        end
      endcase
    end
    // Watchdog and module priority bits held elsewhere are gated here.
    if (i_periph_prot_we && !locked) begin
      next_pprot = i_periph_prot_wdata;
    end
  end

  // Register the configuration state; reset returns to privileged operation.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg0 <= `SCPL_C0_RST;
      cfg1 <= `SCPL_C1_RST;
      cfg2 <= `SCPL_C2_RST;
      pprot <= 4'h0;
      proc_mode <= 1'b0;
      boot_pending <= 1'b1;
    end else begin
      cfg0 <= next_cfg0;
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      pprot <= next_pprot;
      proc_mode <= next_proc_mode;
      boot_pending <= next_boot_pending;
    end
  end

  // Remembers that a reset release already happened, so later resets are warm.
  always_ff @(posedge i_clock) begin
    started <= next_started;
  end

  // ----------------------------------------------------------------------------
  // Memory routing
  // ----------------------------------------------------------------------------
  scpl_decode u_decode (
    .i_addr(eff_addr),
    .i_proc_mode(proc_mode),
    .i_mem_off(cfg1[`SCPL_C1_MEMOFF]),
    .o_internal(dec_internal),
    .o_external(dec_external),
    .o_low_window(dec_low),
    .o_upper_window(dec_upper),
    .o_periph_window(dec_periph)
  );

  // ----------------------------------------------------------------------------
  // Port function and external strobes
  // ----------------------------------------------------------------------------
  scpl_port_fn_t next_port_fn;
  logic ext_now;
  logic sel_ok;

  // Processor mode forces bus control; selects only exist in expanded computer mode.
  always_comb begin
    if (proc_mode) begin
      next_port_fn = SCPL_PORT_BUSCTL;
    end else begin
      next_port_fn = i_port_fn_req;
    end
    ext_now = i_access && dec_external && !boot_pending;
    sel_ok = !proc_mode && (o_port_fn == SCPL_PORT_SELECTS) && ext_now;
  end

  // Output registers follow the strobe timing of the external access.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_port_fn <= SCPL_PORT_GPIO;
      o_external_strobe_n <= 1'b1;
      o_opcode_fetch_out_n <= 1'b1;
      o_wait_stall <= 1'b0;
      o_low_window_select_a_n <= 1'b1;
      o_low_window_select_b_n <= 1'b1;
      o_upper_bank_select_1_n <= 1'b1;
      o_upper_bank_select_2_n <= 1'b1;
      o_upper_bank_select_3_n <= 1'b1;
      o_periph_ext_select_n <= 1'b1;
      o_internal_sel <= 1'b0;
      o_rdata <= 8'h00;
      o_mode <= SCPL_MODE_SINGLE;
      o_privileged <= 1'b1;
      o_cfg0 <= 8'h00;
      o_cfg1 <= 8'h00;
      o_cfg2 <= 8'h00;
      o_periph_prot <= 4'h0;
    end else begin
      o_port_fn <= next_port_fn;
      o_external_strobe_n <= !(ext_now && o_port_fn == SCPL_PORT_BUSCTL);
      o_opcode_fetch_out_n <= !(ext_now && i_opcode_fetch && o_port_fn == SCPL_PORT_BUSCTL);
      o_wait_stall <= ext_now && !i_wait_n && o_port_fn == SCPL_PORT_BUSCTL;
      o_low_window_select_a_n <= !(sel_ok && dec_low && i_select_enable[0]);
      o_low_window_select_b_n <= !(sel_ok && dec_low && i_select_enable[1]);
      o_upper_bank_select_1_n <= !(sel_ok && dec_upper && i_select_enable[2]);
      o_upper_bank_select_2_n <= !(sel_ok && dec_upper && i_select_enable[3]);
      o_upper_bank_select_3_n <= !(sel_ok && dec_upper && i_select_enable[4]);
      o_periph_ext_select_n <= !(sel_ok && dec_periph && i_select_enable[5]);
      o_internal_sel <= i_access && dec_internal;
      o_rdata <= (widx == 2'd0) ? cfg0 : (widx == 2'd1) ? cfg1 : (widx == 2'd2) ? cfg2 : 8'h00;
      o_mode <= proc_mode ? SCPL_MODE_PROC
        : (next_port_fn == SCPL_PORT_GPIO ? SCPL_MODE_SINGLE : SCPL_MODE_EXPANDED);
      o_privileged <= !cfg2[`SCPL_C2_LOCK];
      o_cfg0 <= cfg0;
      o_cfg1 <= cfg1;
      o_cfg2 <= cfg2;
      o_periph_prot <= pprot;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_lock_holds;
    @(posedge i_clock) disable iff (i_rst)
      cfg2[`SCPL_C2_LOCK] |=> cfg2[`SCPL_C2_LOCK];
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("Lock bit cleared without reset.");

  property p_prot_frozen;
    @(posedge i_clock) disable iff (i_rst)
      locked && !boot_pending |=> ($stable(cfg1) && ((cfg2 & `SCPL_C2_PROT) == ($past(cfg2) & `SCPL_C2_PROT)));
  endproperty
  a_prot_frozen: assert property (p_prot_frozen) else $error("Protected bit changed while locked.");

  property p_unprot_updates;
    @(posedge i_clock) disable iff (i_rst)
      locked && i_access && i_write && !i_pf_access && i_addr == `SCPL_ADDR_CFG2 && !boot_pending
      |=> cfg2[4:3] == $past(i_wdata[4:3]);
  endproperty
  a_unprot_updates: assert property (p_unprot_updates) else $error("Free bits ignored a write.");

  property p_lock_sets;
    @(posedge i_clock) disable iff (i_rst)
      !locked && i_access && i_write && !i_pf_access && i_addr == `SCPL_ADDR_CFG2 && i_wdata[0]
      && !boot_pending |=> locked ##1 !o_privileged;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("Lock write did not take.");

  property p_mode_capture;
    @(posedge i_clock) disable iff (i_rst)
      boot_pending |=> (proc_mode == $past(i_mode_select_pin))
      && (cfg1[`SCPL_C1_MEMOFF] == $past(i_mode_select_pin)) && !locked;
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("Mode not caught at release.");

  property p_proc_busctl;
    @(posedge i_clock) disable iff (i_rst)
      proc_mode && !boot_pending |=> o_port_fn == SCPL_PORT_BUSCTL;
  endproperty
  a_proc_busctl: assert property (p_proc_busctl) else $error("Ports left bus control.");

  property p_gone_window;
    @(posedge i_clock) disable iff (i_rst)
      proc_mode && !cfg1[`SCPL_C1_MEMOFF] && i_access && i_addr >= `SCPL_GONE_LO
      && i_addr <= `SCPL_INT_HI |=> o_external_strobe_n;
  endproperty
  a_gone_window: assert property (p_gone_window) else $error("Strobe in disabled window.");

  property p_selects_proc;
    @(posedge i_clock) disable iff (i_rst)
      proc_mode |-> ##2 (o_low_window_select_a_n && o_upper_bank_select_1_n && o_periph_ext_select_n);
  endproperty
  a_selects_proc: assert property (p_selects_proc) else $error("Chip select in processor mode.");
endmodule : scpl_top

// ==== bench/scpl_ext_mem.sv ====
// Behavioural model of the external memory and peripherals on the expansion bus.
`timescale 1ns/1ns
module scpl_ext_mem (
  input wire logic i_clock,
  input wire logic i_strobe_n,
  input wire logic [3:0] i_stall,
  output logic o_wait_n
);
  logic [3:0] held;
  // ----------------------------------------------------------------------------
  // Wait generation
  // ----------------------------------------------------------------------------
  // Pulls wait low for the requested number of cycles of each strobed access.
  // The line rests high between accesses, as an unused wait pin is pulled up.
  initial begin
    held = 4'h0;
    o_wait_n = 1'b1;
  end
  always @(posedge i_clock) begin
    if (!i_strobe_n && held < i_stall) begin
      held <= held + 4'h1;
      o_wait_n <= 1'b0;
    end else begin
      o_wait_n <= 1'b1;
      if (i_strobe_n) begin
        held <= 4'h0;
      end
    end
  end
endmodule : scpl_ext_mem

// ==== bench/tb_top.sv ====
// Self-checking testbench for the system configuration block.
`timescale 1ns/1ns
`include "scpl_cfg.svh"
module tb_top;
  import scpl_pkg::*;
  logic clock, rst, pin, hv, fault, access, write, pf_access, ofetch, wait_n, pp_we;
  logic [15:0] addr;
  logic [7:0] wdata, pf_num, rdata, cfg0, cfg1, cfg2;
  logic [5:0] sel_en;
  logic [3:0] pp_wdata, pprot, stall;
  scpl_port_fn_t port_req, port_fn;
  scpl_mode_t mode;
  logic priv, int_sel, strobe_n, fetch_n, wstall, sa_n, sb_n, b1_n, b2_n, b3_n, pf_n;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  scpl_top i_dut (
    .i_clock(clock), .i_rst(rst), .i_mode_select_pin(pin), .i_mode_pin_high_voltage(hv),
    .i_clock_fault_seen(fault), .i_addr(addr), .i_access(access), .i_write(write),
    .i_wdata(wdata), .i_pf_access(pf_access), .i_pf_num(pf_num), .i_opcode_fetch(ofetch),
    .i_wait_n(wait_n), .i_port_fn_req(port_req), .i_select_enable(sel_en),
    .i_periph_prot_wdata(pp_wdata), .i_periph_prot_we(pp_we), .o_rdata(rdata),
    .o_mode(mode), .o_port_fn(port_fn), .o_privileged(priv), .o_internal_sel(int_sel),
    .o_external_strobe_n(strobe_n), .o_opcode_fetch_out_n(fetch_n), .o_wait_stall(wstall),
    .o_low_window_select_a_n(sa_n), .o_low_window_select_b_n(sb_n),
    .o_upper_bank_select_1_n(b1_n), .o_upper_bank_select_2_n(b2_n),
    .o_upper_bank_select_3_n(b3_n), .o_periph_ext_select_n(pf_n), .o_cfg0(cfg0),
    .o_cfg1(cfg1), .o_cfg2(cfg2), .o_periph_prot(pprot)
  );
  scpl_ext_mem i_mem (.i_clock(clock), .i_strobe_n(strobe_n), .i_stall(stall), .o_wait_n(wait_n));
  // ----------------------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------------------
  // Free-running 4 ns clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Cuts a hung run short well beyond the length of the sequence.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------------
  // Compares one byte-wide result and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Resets with the given mode pin level, held steady across the release.
  task automatic do_reset(input logic level);
    @(negedge clock);
    pin = level;
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
  endtask : do_reset
  // Register write, then waits until the register images have settled.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    write = 1'b1;
    access = 1'b1;
    @(negedge clock);
    access = 1'b0;
    write = 1'b0;
    repeat (2) @(negedge clock);
  endtask : wr
  // Register read by address or by short peripheral number.
  task automatic rd(input logic pf, input logic [15:0] a, input logic [7:0] exp);
    addr = a;
    pf_num = a[7:0];
    access = ~pf;
    pf_access = pf;
    repeat (2) @(negedge clock);
    chk(rdata, exp);
    access = 1'b0;
    pf_access = 1'b0;
    @(negedge clock);
  endtask : rd
  // Starts a fetch access, waits one cycle and leaves it standing.
  task automatic acc(input logic [15:0] a);
    addr = a;
    ofetch = 1'b1;
    access = 1'b1;
    @(negedge clock);
  endtask : acc
  // Releases the access and lets the outputs return to idle.
  task automatic rel();
    access = 1'b0;
    ofetch = 1'b0;
    repeat (2) @(negedge clock);
  endtask : rel
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  // Works through computer mode, the lock, an unlocking reset and processor mode.
  initial begin
    rst = 1'b1; pin = 1'b0; hv = 1'b0; fault = 1'b0; access = 1'b0; write = 1'b0;
    pf_access = 1'b0; ofetch = 1'b0; pp_we = 1'b0; addr = 16'h0000; wdata = 8'h00;
    pf_num = 8'h00; sel_en = 6'h00; pp_wdata = 4'h0; stall = 4'h0; port_req = SCPL_PORT_GPIO;
    do_reset(1'b0);
    chk({6'h00, mode}, {6'h00, SCPL_MODE_SINGLE});
    chk(cfg0 & 8'h0d, 8'h00);
    chk({7'h00, priv}, 8'h01);
    chk(cfg1, 8'h00);
    chk(cfg2, 8'h00);
    wr(`SCPL_ADDR_CFG1, 8'h14);
    chk(cfg1, 8'h14);
    wr(`SCPL_ADDR_CFG0, 8'h60);
    chk(cfg0 & 8'h60, 8'h60);
    fault = 1'b1;
    @(negedge clock);
    fault = 1'b0;
    repeat (2) @(negedge clock);
    chk(cfg0 & 8'h10, 8'h10);
    wr(`SCPL_ADDR_CFG2, 8'hc6);
    chk(cfg2, 8'hc6);
    rd(1'b1, 16'h1012, 8'hc6);
    rd(1'b0, `SCPL_ADDR_CFG1, 8'h14);
    rd(1'b0, 16'h1013, 8'h00);
    pp_wdata = 4'h5;
    pp_we = 1'b1;
    @(negedge clock);
    pp_we = 1'b0;
    repeat (2) @(negedge clock);
    chk({4'h0, pprot}, 8'h05);
    port_req = SCPL_PORT_SELECTS;
    sel_en = 6'h3f;
    repeat (2) @(negedge clock);
    chk({6'h00, port_fn}, {6'h00, SCPL_PORT_SELECTS});
    chk({6'h00, mode}, {6'h00, SCPL_MODE_EXPANDED});
    // Select vector order: low a, low b, bank 1, bank 2, bank 3, peripheral.
    acc(16'h2000);
    chk({2'b00, sa_n, sb_n, b1_n, b2_n, b3_n, pf_n}, 8'h0f);
    acc(16'h8000);
    chk({2'b00, sa_n, sb_n, b1_n, b2_n, b3_n, pf_n}, 8'h31);
    acc(16'h10c0);
    chk({2'b00, sa_n, sb_n, b1_n, b2_n, b3_n, pf_n}, 8'h3e);
    acc(16'h7000);
    chk({2'b00, sa_n, sb_n, b1_n, b2_n, b3_n, pf_n}, 8'h3f);
    chk({7'h00, int_sel}, 8'h01);
    rel();
    port_req = SCPL_PORT_BUSCTL;
    repeat (2) @(negedge clock);
    acc(16'h2000);
    chk({7'h00, strobe_n}, 8'h00);
    chk({7'h00, fetch_n}, 8'h00);
    rel();
    port_req = SCPL_PORT_GPIO;
    wr(`SCPL_ADDR_CFG2, 8'hc7);
    chk({7'h00, priv}, 8'h00);
    wr(`SCPL_ADDR_CFG1, 8'h00);
    chk(cfg1, 8'h14);
    wr(`SCPL_ADDR_CFG2, 8'h18);
    chk(cfg2, 8'hdf);
    pp_wdata = 4'ha;
    pp_we = 1'b1;
    @(negedge clock);
    pp_we = 1'b0;
    hv = 1'b1;
    wr(`SCPL_ADDR_CFG1, 8'h00);
    chk(cfg1, 8'h14);
    chk({4'h0, pprot}, 8'h05);
    chk(cfg0 & 8'h08, 8'h08);
    hv = 1'b0;
    do_reset(1'b0);
    chk({7'h00, priv}, 8'h01);
    chk(cfg2, 8'h00);
    do_reset(1'b1);
    chk({6'h00, mode}, {6'h00, SCPL_MODE_PROC});
    chk(cfg0 & 8'h05, 8'h05);
    chk(cfg1, 8'h04);
    chk({6'h00, port_fn}, {6'h00, SCPL_PORT_BUSCTL});
    acc(16'h7ffe);
    chk({7'h00, strobe_n}, 8'h00);
    chk({7'h00, int_sel}, 8'h00);
    rel();
    wr(`SCPL_ADDR_CFG1, 8'h00);
    acc(16'h7000);
    chk({7'h00, strobe_n}, 8'h01);
    chk({7'h00, int_sel}, 8'h01);
    acc(16'h4000);
    chk({7'h00, strobe_n}, 8'h01);
    rel();
    // The partner pulls wait low one cycle after the strobe goes low, so hold the access.
    stall = 4'h2;
    acc(16'h8000);
    chk({7'h00, strobe_n}, 8'h00);
    repeat (2) @(negedge clock);
    chk({7'h00, wstall}, 8'h01);
    chk({7'h00, strobe_n}, 8'h00);
    rel();
    chk({6'h00, wstall, strobe_n}, 8'h01);
    stall = 4'h0;
    repeat (4) @(negedge clock);
    complete_run();
  end
endmodule : tb_top
